// ===== logic/dmp_regs.vh
`ifndef DMP_REGS_VH
`define DMP_REGS_VH
// Port widths
`define DMP_ADDR_W      32
`define DMP_DATA_W      40
`define DMP_WORD_W      32
`define DMP_WORD_LSB    8
`define DMP_BANKS       4
`define DMP_BANK_SEL_W  2
// Default bank decode: two top address bits pick the bank
`define DMP_BANK_LSB    30
// Default page size as log2 of words
`define DMP_PAGE_LOG2   8
// Core port command encodings
`define DMP_CMD_IDLE    2'b00
`define DMP_CMD_READ    2'b01
`define DMP_CMD_WRITE   2'b10
`endif

// ===== logic/dmp_sync.v
`timescale 1ns/1ps
`include "dmp_regs.vh"
module dmp_sync #(
    parameter RESET_VAL = 1'b1
) (
    // Clock and reset
    input  wire clk_in,
    input  wire reset_in,
    // Asynchronous level in, synchronised level out
    input  wire async_in,
    output wire sync_out
);
    reg stage1_q;
    reg stage2_q;

    // Two stages; only the second stage is read
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            stage1_q <= RESET_VAL;
            stage2_q <= RESET_VAL;
        end else begin
            stage1_q <= async_in;
            stage2_q <= stage1_q;
        end
    end

    assign sync_out = stage2_q;
endmodule

// ===== logic/dmp_port.v
`timescale 1ns/1ps
`include "dmp_regs.vh"
// What this block does
// - Read strobe asserted throughout every read cycle
// - Write strobe asserted throughout every write cycle
// - Deasserted acknowledge inserts wait states, holds access
// - Page output flags access crossing configured page
// - Float input low floats address, data, selects, strobes
// - Float during access halts core, access pending
// - Bus request: finish cycle, halt, float, grant
// - Grant held while request held, then resume
// - Reset gives known state, strobes inactive
// - 32-bit words ride data bus bits 39 to 8
// - Bank selects decoded from the address
module dmp_port #(
    parameter BANK_LSB  = `DMP_BANK_LSB,
    parameter PAGE_LOG2 = `DMP_PAGE_LOG2
) (
    // Clock and reset
    input  wire                        CLK_IN,
    input  wire                        RESET_IN,
    // Core request side
    input  wire [1:0]                  CORE_CMD_IN,
    input  wire [`DMP_ADDR_W-1:0]      CORE_ADDR_IN,
    input  wire [`DMP_WORD_W-1:0]      CORE_WDATA_IN,
    input  wire                        CORE_EXT_IN,
    output wire                        CORE_READY_OUT,
    output wire                        CORE_HALT_OUT,
    output reg  [`DMP_DATA_W-1:0]      CORE_RDATA_OUT,
    output reg                         CORE_RVALID_OUT,
    // Memory address and selects
    output reg  [`DMP_ADDR_W-1:0]      ADDR_OUT,
    output wire                        ADDR_OE_OUT,
    output reg  [`DMP_BANKS-1:0]       BANK_SEL_N_OUT,
    // Memory data bus
    input  wire [`DMP_DATA_W-1:0]      DATA_IN,
    output reg  [`DMP_DATA_W-1:0]      DATA_OUT,
    output wire                        DATA_OE_OUT,
    // Strobes and page flag
    output wire                        READ_STROBE_N_OUT,
    output wire                        WRITE_STROBE_N_OUT,
    output wire                        STROBE_OE_OUT,
    output reg                         PAGE_CROSSING_OUT,
    // Memory handshake and float
    input  wire                        ACKNOWLEDGE_IN,
    input  wire                        PORT_FLOAT_N_IN,
    // Bus hold
    input  wire                        HOLD_REQUEST_N_IN,
    output wire                        HOLD_GRANT_N_OUT
);
    ////////////////////////////////////////////////////////////////////////////
    // States
    // Hold is a state of its own so no access can start while granted
    localparam ST_IDLE  = 2'd0;
    localparam ST_READ  = 2'd1;
    localparam ST_WRITE = 2'd2;
    localparam ST_HOLD  = 2'd3;

    reg  [1:0]             state_q;
    reg  [1:0]             state_d;
    reg                    grant_q;
    // Last address seen, for the page-crossing compare
    reg  [`DMP_ADDR_W-1:0] last_addr_q;
    reg                    last_valid_q;
    wire                   hold_req_n;
    wire                   access_on;
    wire                   floated;
    wire                   done;
    wire                   start;
    wire                   rd_done;

    // Request is asynchronous, so it passes two flops first
    // The two cycles of latency delay the grant, and after release also the return to idle and the next access
    dmp_sync #(
        .RESET_VAL (1'b1)
    ) u_req_sync (
        .clk_in    (CLK_IN),
        .reset_in  (RESET_IN),
        .async_in  (HOLD_REQUEST_N_IN),
        .sync_out  (hold_req_n)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    // Active-low one-hot select from the bank field of the address
    function [`DMP_BANKS-1:0] bank_dec;
        input [`DMP_ADDR_W-1:0] a;
        reg   [`DMP_BANK_SEL_W-1:0] b;
        begin
            b = a[BANK_LSB +: `DMP_BANK_SEL_W];
            bank_dec = ~({{(`DMP_BANKS-1){1'b0}}, 1'b1} << b);
        end
    endfunction

    // Page number: the address bits above the page size
    function [`DMP_ADDR_W-PAGE_LOG2-1:0] page_of;
        input [`DMP_ADDR_W-1:0] a;
        begin
            page_of = a[`DMP_ADDR_W-1:PAGE_LOG2];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Handshake terms
    // Access in progress, stalled or not
    assign access_on = (state_q == ST_READ) || (state_q == ST_WRITE);
    // Float floats the pins in any state; mid access it also keeps the access from completing
    assign floated   = ~PORT_FLOAT_N_IN;
    // An access completes only when acknowledged and not floated
    assign done      = access_on && ACKNOWLEDGE_IN && !floated;
    // Ready is combinational; in idle a command is taken on the very next edge, after done one edge later
    assign CORE_READY_OUT = (state_q == ST_IDLE && hold_req_n) || done;
    assign CORE_HALT_OUT  = (state_q == ST_HOLD) || (access_on && !done);
    // A new access is launched on the edge that leaves idle for read or write
    assign start   = (state_q == ST_IDLE) && (state_d == ST_READ || state_d == ST_WRITE);
    // Read data is only worth capturing on the edge a read completes
    assign rd_done = done && (state_q == ST_READ);

    ////////////////////////////////////////////////////////////////////////////
    // Next state: new access starts only from idle with no hold pending
    // Hold is entered only from idle or at the end of an access
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                // A pending hold wins over a new core command
                if (!hold_req_n) begin
                    state_d = ST_HOLD;
                end else if (CORE_EXT_IN && CORE_CMD_IN == `DMP_CMD_READ) begin
                    state_d = ST_READ;
                end else if (CORE_EXT_IN && CORE_CMD_IN == `DMP_CMD_WRITE) begin
                    state_d = ST_WRITE;
                end
            end
            ST_READ, ST_WRITE: begin
                // Current cycle finishes before a hold is honoured
                if (done) begin
                    state_d = hold_req_n ? ST_IDLE : ST_HOLD;
                end
            end
            ST_HOLD: begin
                // Hold ends once the synchronised request is high
                if (hold_req_n) begin
                    state_d = ST_IDLE;
                end
            end
            // Unused code falls back to idle
            default: state_d = ST_IDLE;
        endcase
    end

    // State, grant and strobes reset to inactive
    always @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            state_q <= ST_IDLE;
            // Sync stage also resets high, so no grant follows reset
            grant_q <= 1'b0;
        end else begin
            state_q <= state_d;
            // Grant one cycle into hold, once strobes have already gone high
            grant_q <= (state_q == ST_HOLD) && hold_req_n == 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address, data and page tracking, latched at access start
    always @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            ADDR_OUT          <= {`DMP_ADDR_W{1'b0}};
            BANK_SEL_N_OUT    <= {`DMP_BANKS{1'b1}};
            DATA_OUT          <= {`DMP_DATA_W{1'b0}};
            PAGE_CROSSING_OUT <= 1'b0;
            last_addr_q       <= {`DMP_ADDR_W{1'b0}};
            last_valid_q      <= 1'b0;
        end else if (start) begin
            ADDR_OUT       <= CORE_ADDR_IN;
            BANK_SEL_N_OUT <= bank_dec(CORE_ADDR_IN);
            DATA_OUT       <= {CORE_WDATA_IN, {`DMP_WORD_LSB{1'b0}}};
            PAGE_CROSSING_OUT <= last_valid_q &&
                (page_of(CORE_ADDR_IN) != page_of(last_addr_q));
            last_addr_q    <= CORE_ADDR_IN;
            // First access after reset has nothing to compare with
            last_valid_q   <= 1'b1;
        end else if (done) begin
            // Selects released so a bank is not held after the access
            // Address and data stay put; only the select and flag drop
            BANK_SEL_N_OUT    <= {`DMP_BANKS{1'b1}};
            PAGE_CROSSING_OUT <= 1'b0;
        end
    end

    // Read data captured on the completing edge
    always @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            CORE_RDATA_OUT  <= {`DMP_DATA_W{1'b0}};
            CORE_RVALID_OUT <= 1'b0;
        end else begin
            CORE_RVALID_OUT <= rd_done;
            // Full 40-bit bus kept; 32-bit words sit in bits 39 to 8
            if (rd_done) begin
                CORE_RDATA_OUT <= DATA_IN;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive: float while floated or granted
    // Strobes come straight from the state, so they last the whole access
    assign READ_STROBE_N_OUT  = ~(state_q == ST_READ);
    assign WRITE_STROBE_N_OUT = ~(state_q == ST_WRITE);
    // Hold drives the strobes high for one cycle and floats only with grant,
    // so memory never sees a strobe cut off while the pins float
    assign ADDR_OE_OUT   = !floated && !grant_q;
    assign STROBE_OE_OUT = ADDR_OE_OUT;
    // Data is driven only while writing, so a read never fights memory
    assign DATA_OE_OUT   = ADDR_OE_OUT && state_q == ST_WRITE;
    // Grant pin is the inverse of a register, free of glitches
    assign HOLD_GRANT_N_OUT = ~grant_q;
endmodule

// ===== verif/dmp_port_asserts.sv
`timescale 1ns/1ps
module dmp_port_asserts (
    input logic        CLK_IN, RESET_IN, ACKNOWLEDGE_IN, PORT_FLOAT_N_IN,
    input logic        HOLD_REQUEST_N_IN, HOLD_GRANT_N_OUT, CORE_HALT_OUT,
    input logic        CORE_RVALID_OUT, ADDR_OE_OUT, STROBE_OE_OUT, DATA_OE_OUT,
    input logic        READ_STROBE_N_OUT, WRITE_STROBE_N_OUT,
    input logic [31:0] ADDR_OUT,
    input logic [39:0] DATA_OUT,
    input logic [3:0]  BANK_SEL_N_OUT
);
    // An access may only end on an edge with acknowledge up and the port driven
    wire fin = ACKNOWLEDGE_IN & PORT_FLOAT_N_IN;
    wire rd = !READ_STROBE_N_OUT;
    wire wr = !WRITE_STROBE_N_OUT;
    wire gnt = !HOLD_GRANT_N_OUT;
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);
    a_read_held: assert property (rd && !fin |=> rd) else $error("read left");
    a_write_held: assert property (wr && !fin |=> wr) else $error("write left");
    a_read_ends: assert property (rd && fin |=> !rd && CORE_RVALID_OUT) else $error("no end");
    a_float_pins: assert property (!PORT_FLOAT_N_IN |-> !(ADDR_OE_OUT | STROBE_OE_OUT | DATA_OE_OUT))
        else $error("driven in float");
    a_float_halt: assert property (!PORT_FLOAT_N_IN && (rd | wr) |-> CORE_HALT_OUT)
        else $error("ran in float");
    a_grant_quiet: assert property (gnt |-> !ADDR_OE_OUT && !rd && !wr) else $error("busy");
    a_grant_cause: assert property ($fell(HOLD_GRANT_N_OUT) |-> !$past(HOLD_REQUEST_N_IN, 2))
        else $error("grant unasked");
    a_grant_kept: assert property (gnt && !HOLD_REQUEST_N_IN |=> gnt) else $error("grant off");
    a_grant_drop: assert property (HOLD_REQUEST_N_IN [*5] |-> !gnt) else $error("grant on");
    a_reset_quiet: assert property (disable iff (1'b0) RESET_IN |-> !rd && !wr && !gnt)
        else $error("active in reset");
    a_word_lanes: assert property (wr |-> DATA_OUT[7:0] == 8'h00) else $error("low lanes");
    a_bank_decode: assert property (rd | wr |-> BANK_SEL_N_OUT == ~(4'h1 << ADDR_OUT[31:30]))
        else $error("bank select");
endmodule
bind dmp_port dmp_port_asserts u_chk (.*);

// ===== verif/dmp_mem_model.sv
`timescale 1ns/1ps
module dmp_mem_model (
    input  wire        clk_in, reset_in, rd_n_in, wr_n_in,
    input  wire [31:0] addr_in,
    input  wire [39:0] wdata_in,
    input  wire [3:0]  wait_in,
    output wire [39:0] rdata_out,
    output wire        ack_out
);
    reg [39:0] mem_q [0:15];
    reg [39:0] last_q;
    reg [3:0]  cnt_q;
    // Released bus shows the inverse of its last value, so no stale copy passes
    assign rdata_out = rd_n_in ? ~last_q : mem_q[addr_in[3:0]];
    // Acknowledge waits out the wait states, then stays up until the strobe goes
    assign ack_out = cnt_q >= wait_in;
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            cnt_q <= 4'h0;
            last_q <= 40'h00_0000_0000;
        end else begin
            cnt_q <= (rd_n_in & wr_n_in) ? 4'h0 : cnt_q + {3'h0, !ack_out};
            last_q <= rdata_out;
            if (!wr_n_in && ack_out) mem_q[addr_in[3:0]] <= wdata_in;
        end
    end
endmodule

// ===== verif/data_memory_port_bus_handoff_tb_top.sv
`timescale 1ns/1ps
module data_memory_port_bus_handoff_tb_top;
    reg         clk = 1'b0, rst = 1'b0, ext = 1'b1, fl_n = 1'b1, req_n = 1'b1, first = 1'b1;
    reg  [1:0]  cmd = 2'b00;
    reg  [3:0]  wt = 4'h0;
    reg  [31:0] adr = 32'h0000_0000, wd = 32'h0000_0000, prev = 32'h0000_0000, r;
    reg  [31:0] exp_m [0:15];
    wire [39:0] rdat, din, dout;
    wire [31:0] aout;
    wire        rd_n, wr_n, ack, rdy, hlt, gnt_n, rv, aoe, pg;
    integer     seed = 77483, n_mismatch = 0, cmp_count = 0, cyc = 0, i, k;
    dmp_port dut (.CLK_IN(clk), .RESET_IN(rst), .CORE_CMD_IN(cmd), .CORE_ADDR_IN(adr),
        .CORE_WDATA_IN(wd), .CORE_EXT_IN(ext), .CORE_READY_OUT(rdy), .CORE_HALT_OUT(hlt),
        .CORE_RDATA_OUT(rdat), .CORE_RVALID_OUT(rv), .ADDR_OUT(aout), .ADDR_OE_OUT(aoe),
        .BANK_SEL_N_OUT(), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE_OUT(),
        .READ_STROBE_N_OUT(rd_n), .WRITE_STROBE_N_OUT(wr_n), .STROBE_OE_OUT(),
        .PAGE_CROSSING_OUT(pg), .ACKNOWLEDGE_IN(ack), .PORT_FLOAT_N_IN(fl_n),
        .HOLD_REQUEST_N_IN(req_n), .HOLD_GRANT_N_OUT(gnt_n));
    dmp_mem_model u_mem (.clk_in(clk), .reset_in(rst), .rd_n_in(rd_n), .wr_n_in(wr_n),
        .addr_in(aout), .wdata_in(dout), .wait_in(wt), .rdata_out(din), .ack_out(ack));
    ////////////////////////////////////////////////////////////////////////////////
    // Free-running clock, never halted
    initial forever #2.5 clk = ~clk;
    // Cut a hang short; the whole run needs a few hundred cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch = n_mismatch + 1;
            stop_test;
        end
    end
    task chk(input string nm, input [39:0] got, input [39:0] want);
        cmp_count = cmp_count + 1;
        if (got !== want) begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %0s expected %h seen %h", nm, want, got);
        end
    endtask
    task stop_test;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Wait, bounded, until read strobe, write strobe or grant reaches a level
    task till(input integer s, input v);
        k = 0;
        while ((s == 0 ? rd_n : s == 1 ? wr_n : gnt_n) !== v && k < 40) begin
            @(posedge clk);
            #1;
            k = k + 1;
        end
        chk("wait", k < 40, 1);
    endtask
    // One access; an optional float stretches it while the far side stalls
    task acc(input w, input [31:0] a, input integer fl);
        @(posedge clk);
        cmd <= w ? 2'b10 : 2'b01;
        adr <= a;
        wd <= $random(seed);
        r = $random(seed);
        wt <= {2'b00, r[1:0]};
        // Ready seen between edges is what the next edge samples
        #1;
        while (!rdy) begin
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        cmd <= 2'b00;
        // Float starts on the edge the access opens, so it lands mid access
        if (fl > 0) fl_n <= 1'b0;
        #1;
        till(w, 0);
        chk("page", pg, !first && a[31:8] != prev[31:8]);
        if (fl > 0) begin
            repeat (fl) @(posedge clk);
            #1;
            chk("float", {aoe, w ? wr_n : rd_n, hlt}, 3'b001);
            @(posedge clk);
            fl_n <= 1'b1;
        end
        till(w, 1);
        if (w) exp_m[a[3:0]] = wd;
        else begin
            chk("rvalid", rv, 1);
            chk("rdata", rdat, {exp_m[a[3:0]], 8'h00});
        end
        prev = a;
        first = 1'b0;
    endtask
    initial begin
        // Reset rises at time zero so the async branch runs before the first edge
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 32; i = i + 1) begin
            r = $random(seed);
            acc(i < 16, (r & 32'hC000_01F0) | i[3:0], (i % 5 == 3) ? 4 : 0);
        end
        // An internal command must leave the external port idle
        @(posedge clk);
        ext <= 1'b0;
        cmd <= 2'b01;
        repeat (2) @(posedge clk);
        #1;
        chk("internal", rd_n, 1);
        @(posedge clk);
        cmd <= 2'b00;
        ext <= 1'b1;
        $display("test access done");
        @(posedge clk);
        req_n <= 1'b0;
        till(2, 0);
        chk("grant", {aoe, rd_n, wr_n}, 3'b011);
        repeat (3) @(posedge clk);
        #1;
        chk("held", gnt_n, 0);
        @(posedge clk);
        req_n <= 1'b1;
        till(2, 1);
        $display("test hold done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        #1;
        chk("reset", {rd_n, wr_n, gnt_n}, 3'b111);
        @(posedge clk);
        rst <= 1'b0;
        first = 1'b1;
        acc(0, 32'h4000_0105, 0);
        $display("test reset done");
        stop_test;
    end
endmodule
